// ==== design/cocc_pkg.sv ====
// Shared constants and types of the clock output control block
package cocc_pkg;

   // ==========================================================
   // Geometry
   localparam int NUM_OUT = 8;
   localparam int WORD_W = 32;
   localparam int ADDR_W = 4;
   localparam int NUM_REG = 16;

   // ==========================================================
   // Serial word layout
   localparam int ADDR_LSB = 0;
   localparam int DLY_LSB = 4;
   localparam int DLY_W = 4;
   localparam int DIV_LSB = 8;
   localparam int DIV_W = 8;
   localparam int EN_BIT = 16;
   localparam int MUX_LSB = 17;
   localparam int MUX_W = 2;
   localparam int RESET_BIT = 31;
   localparam int GLOBAL_EN_BIT = 27;
   localparam int PLL_MUX_LSB = 20;
   localparam int PLL_MUX_W = 3;
   localparam logic [ADDR_W-1:0] REG_RESET = 4'h0;
   localparam logic [ADDR_W-1:0] REG_GLOBAL = 4'he;

   // ==========================================================
   // Encodings
   localparam logic [MUX_W-1:0] MUX_BYPASS = 2'h0;
   localparam logic [MUX_W-1:0] MUX_DIVIDED = 2'h1;
   localparam logic [MUX_W-1:0] MUX_DELAYED = 2'h2;
   localparam logic [MUX_W-1:0] MUX_DIV_DLY = 2'h3;
   localparam logic [PLL_MUX_W-1:0] PLL_MUX_DLD_HIGH = 3'h3;

   // ==========================================================
   // Timing
   localparam int DLY_STEP_PS = 150;
   localparam int DLY_RANGE_PS = 2250;
   localparam logic [DLY_W-1:0] DLY_MAX_CODE = DLY_W'(DLY_RANGE_PS / DLY_STEP_PS);
   localparam int SYNC_EXTRA_CYCLES = 4;
   localparam logic [DIV_W:0] MIN_PERIOD = 9'h002;

   // ==========================================================
   // Register bus map
   localparam int AXI_ADDR_W = 8;
   localparam logic [AXI_ADDR_W-1:0] STATUS_OFFSET = 8'h40;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int STAT_PENDING = 0;
   localparam int STAT_LOCK = 1;

   // ==========================================================
   // Defaults
   typedef logic [NUM_REG-1:0][WORD_W-1:0] cocc_bank_type;
   localparam logic [WORD_W-1:0] DEFAULT_WORD = 32'h0000_0000;
   localparam logic [WORD_W-1:0] DEFAULT_GLOBAL_WORD = 32'h0800_000e;

   function automatic cocc_bank_type default_bank();
      cocc_bank_type b;
      for (int i = 0; i < NUM_REG; i++) begin
         b[i] = DEFAULT_WORD | WORD_W'(i);
      end
      b[REG_GLOBAL] = DEFAULT_GLOBAL_WORD;
      return b;
   endfunction : default_bank

   typedef enum logic [1:0] {
      OUT_OFF = 2'b00,
      OUT_LOW = 2'b01,
      OUT_RUN = 2'b10
   } cocc_out_state_type;

endpackage : cocc_pkg

// ==== design/cocc_serial_shift.sv ====
// Serial configuration shift register on the serial clock
`timescale 1ns/1ps
`default_nettype none
module cocc_serial_shift (
   input wire logic scfg_clk,
   input wire logic rstn,
   input wire logic scfg_data,
   input wire logic scfg_latch,
   output logic [cocc_pkg::WORD_W-1:0] word
);
   typedef struct packed {
      logic [cocc_pkg::WORD_W-1:0] sh;
   } cocc_shift_type;

   cocc_shift_type s;
   cocc_shift_type next_s;

   always_comb begin
      next_s = s;
      // Bits only move while the latch line is low
      if (!scfg_latch) begin
         next_s.sh = {s.sh[cocc_pkg::WORD_W-2:0], scfg_data};
      end
   end

   always_ff @(posedge scfg_clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Held still while the latch is high and the serial clock idles
   assign word = s.sh;
endmodule : cocc_serial_shift
`default_nettype wire

// ==== design/cocc_output_channel.sv ====
// One clock output: gating, divider and delay code on the distribution clock
`timescale 1ns/1ps
`default_nettype none
module cocc_output_channel (
   input wire logic dist_clk,
   input wire logic rstn,
   input wire logic cfg_enable,
   input wire logic cfg_global,
   input wire logic goe_level,
   input wire logic sync_hold,
   input wire logic [cocc_pkg::MUX_W-1:0] cfg_mux,
   input wire logic [cocc_pkg::DIV_W-1:0] cfg_div,
   input wire logic [cocc_pkg::DLY_W-1:0] cfg_dly,
   output logic clk_out,
   output logic clk_out_oe,
   output logic [cocc_pkg::DLY_W-1:0] out_delay
);
   typedef struct packed {
      cocc_pkg::cocc_out_state_type state;
      logic [cocc_pkg::DIV_W:0] cnt;
      logic level;
      logic [cocc_pkg::DLY_W-1:0] dly;
   } cocc_chan_type;

   cocc_chan_type s;
   cocc_chan_type next_s;
   cocc_pkg::cocc_out_state_type want;
   logic [cocc_pkg::DIV_W:0] period;
   logic [cocc_pkg::DIV_W:0] wrap;

   always_comb begin
      next_s = s;
      if (!cfg_global || !cfg_enable) begin
         want = cocc_pkg::OUT_OFF;
      end else if (!goe_level || sync_hold) begin
         want = cocc_pkg::OUT_LOW;
      end else begin
         want = cocc_pkg::OUT_RUN;
      end
      // Bypass runs at the fastest toggle rate the flop can make
      if (cfg_mux == cocc_pkg::MUX_DIVIDED || cfg_mux == cocc_pkg::MUX_DIV_DLY) begin
         period = ({1'b0, cfg_div} < cocc_pkg::MIN_PERIOD) ? cocc_pkg::MIN_PERIOD : {1'b0, cfg_div};
      end else begin
         period = cocc_pkg::MIN_PERIOD;
      end
      wrap = s.cnt + 9'h001;
      // A high phase in progress is finished first, so no runt pulse
      if (s.state == cocc_pkg::OUT_RUN && s.level && want != cocc_pkg::OUT_RUN) begin
         next_s.state = cocc_pkg::OUT_RUN;
      end else begin
         next_s.state = want;
      end
      case (next_s.state)
         cocc_pkg::OUT_RUN: begin
            // Counter restarts at release so all outputs rise on one edge
            if (s.state != cocc_pkg::OUT_RUN || wrap >= period) begin
               next_s.cnt = '0;
            end else begin
               next_s.cnt = wrap;
            end
            next_s.level = next_s.cnt < (period >> 1);
         end
         default: begin
            next_s.cnt = '0;
            next_s.level = 1'b0;
         end
      endcase
      if (cfg_mux == cocc_pkg::MUX_DELAYED || cfg_mux == cocc_pkg::MUX_DIV_DLY) begin
         next_s.dly = (cfg_dly > cocc_pkg::DLY_MAX_CODE) ? cocc_pkg::DLY_MAX_CODE : cfg_dly;
      end else begin
         next_s.dly = '0;
      end
   end

   always_ff @(posedge dist_clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign clk_out = s.level;
   assign clk_out_oe = (s.state != cocc_pkg::OUT_OFF);
   assign out_delay = s.dly;
endmodule : cocc_output_channel
`default_nettype wire

// ==== design/cocc_clock_output_control.sv ====
// Top of the clock output control block: register bank, bus slave, crossings
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module cocc_clock_output_control #(
   parameter int NUM_OUT = cocc_pkg::NUM_OUT
) (
   input wire logic CORE_CLK,
   input wire logic RSTN,
   input wire logic SERIAL_CFG_CLOCK,
   input wire logic SERIAL_CFG_DATA,
   input wire logic SERIAL_CFG_LATCH,
   input wire logic DIST_CLK,
   input wire logic GLOBAL_OUTPUT_ENABLE_PIN,
   input wire logic SYNC_N,
   input wire logic PLL_LOCKED,
   output logic LOCK_DETECT_PIN,
   output logic [NUM_OUT-1:0] CLK_OUT,
   output logic [NUM_OUT-1:0] CLK_OUT_OE,
   output logic [NUM_OUT*cocc_pkg::DLY_W-1:0] PER_OUTPUT_DELAY,
   input wire logic [cocc_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [cocc_pkg::WORD_W-1:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [cocc_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [cocc_pkg::WORD_W-1:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);

   // ==========================================================
   // Core clock state
   typedef struct packed {
      cocc_pkg::cocc_bank_type bank;
      cocc_pkg::cocc_bank_type snap;
      logic le_s1;
      logic le_s2;
      logic le_s3;
      logic lock_s1;
      logic lock_s2;
      logic ack_s1;
      logic ack_s2;
      logic req;
      logic pend;
      logic ld;
      logic aw_got;
      logic [cocc_pkg::AXI_ADDR_W-1:0] aw_addr;
      logic w_got;
      logic [cocc_pkg::WORD_W-1:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [cocc_pkg::WORD_W-1:0] rdata;
      logic [1:0] rresp;
   } cocc_core_type;

   // ==========================================================
   // Distribution clock state
   typedef struct packed {
      cocc_pkg::cocc_bank_type cfg;
      logic req_s1;
      logic req_s2;
      logic req_s3;
      logic goe_s1;
      logic goe_s2;
      logic sync_s1;
      logic sync_s2;
      logic [cocc_pkg::SYNC_EXTRA_CYCLES-1:0] hold_pipe;
   } cocc_dist_type;

   cocc_core_type c;
   cocc_core_type next_c;
   cocc_dist_type d;
   cocc_dist_type next_d;
   logic [cocc_pkg::WORD_W-1:0] serial_word;
   logic [cocc_pkg::WORD_W-1:0] merged;
   logic [cocc_pkg::WORD_W-1:0] byte_mask;
   logic [cocc_pkg::ADDR_W-1:0] w_idx;
   logic w_mapped;
   logic r_mapped;
   logic [cocc_pkg::WORD_W-1:0] status_word;
   // Fixed image so the reset branches load plain constants
   localparam cocc_pkg::cocc_bank_type DEFAULT_BANK = cocc_pkg::default_bank();

   // ==========================================================
   // Serial port on its own clock
   cocc_serial_shift u_shift (
      .scfg_clk(SERIAL_CFG_CLOCK),
      .rstn(RSTN),
      .scfg_data(SERIAL_CFG_DATA),
      .scfg_latch(SERIAL_CFG_LATCH),
      .word(serial_word)
   );

   // Writing the reset bit of register zero discards the rest of the word
   function automatic cocc_pkg::cocc_bank_type apply_word(
      input cocc_pkg::cocc_bank_type bank,
      input logic [cocc_pkg::ADDR_W-1:0] idx,
      input logic [cocc_pkg::WORD_W-1:0] word
   );
      cocc_pkg::cocc_bank_type b;
      b = bank;
      if (idx == cocc_pkg::REG_RESET && word[cocc_pkg::RESET_BIT]) begin
         b = cocc_pkg::default_bank();
      end else begin
         b[idx] = word;
      end
      return b;
   endfunction : apply_word

   // ==========================================================
   // Bus decode helpers
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         byte_mask[i*8 +: 8] = {8{c.w_strb[i]}};
      end
      w_idx = c.aw_addr[cocc_pkg::ADDR_W+1:2];
      w_mapped = (c.aw_addr < cocc_pkg::STATUS_OFFSET);
      merged = (c.bank[w_idx] & ~byte_mask) | (c.w_data & byte_mask);
      r_mapped = (S_AXI_ARADDR <= cocc_pkg::STATUS_OFFSET);
      status_word = '0;
      status_word[cocc_pkg::STAT_PENDING] = c.pend || (c.req != c.ack_s2);
      status_word[cocc_pkg::STAT_LOCK] = c.lock_s2;
   end

   assign S_AXI_AWREADY = !c.aw_got && !c.bvalid;
   assign S_AXI_WREADY = !c.w_got && !c.bvalid;
   assign S_AXI_ARREADY = !c.rvalid;

   // ==========================================================
   // Core clock next state
   always_comb begin
      next_c = c;
      next_c.le_s1 = SERIAL_CFG_LATCH;
      next_c.le_s2 = c.le_s1;
      next_c.le_s3 = c.le_s2;
      next_c.lock_s1 = PLL_LOCKED;
      next_c.lock_s2 = c.lock_s1;
      next_c.ack_s1 = d.req_s3;
      next_c.ack_s2 = c.ack_s1;

      // Launch a new snapshot only after the last one was taken
      if (c.pend && c.req == c.ack_s2) begin
         next_c.snap = c.bank;
         next_c.req = !c.req;
         next_c.pend = 1'b0;
      end

      // Serial word is quiet once the latch is high: safe to copy here
      if (c.le_s2 && !c.le_s3) begin
         next_c.bank = apply_word(next_c.bank, serial_word[cocc_pkg::ADDR_LSB +: cocc_pkg::ADDR_W],
            serial_word);
         next_c.pend = 1'b1;
      end

      // Write address and data may arrive in either order
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         next_c.aw_got = 1'b1;
         next_c.aw_addr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
         next_c.w_got = 1'b1;
         next_c.w_data = S_AXI_WDATA;
         next_c.w_strb = S_AXI_WSTRB;
      end
      if (c.aw_got && c.w_got) begin
         next_c.aw_got = 1'b0;
         next_c.w_got = 1'b0;
         next_c.bvalid = 1'b1;
         if (w_mapped) begin
            next_c.bank = apply_word(next_c.bank, w_idx, merged);
            next_c.pend = 1'b1;
            next_c.bresp = cocc_pkg::RESP_OKAY;
         end else begin
            next_c.bresp = cocc_pkg::RESP_SLVERR;
         end
      end
      if (c.bvalid && S_AXI_BREADY) begin
         next_c.bvalid = 1'b0;
      end

      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         next_c.rvalid = 1'b1;
         if (!r_mapped) begin
            next_c.rdata = '0;
            next_c.rresp = cocc_pkg::RESP_SLVERR;
         end else if (S_AXI_ARADDR == cocc_pkg::STATUS_OFFSET) begin
            next_c.rdata = status_word;
            next_c.rresp = cocc_pkg::RESP_OKAY;
         end else begin
            next_c.rdata = c.bank[S_AXI_ARADDR[cocc_pkg::ADDR_W+1:2]];
            next_c.rresp = cocc_pkg::RESP_OKAY;
         end
      end
      if (c.rvalid && S_AXI_RREADY) begin
         next_c.rvalid = 1'b0;
      end

      // Lock detect pin only shows lock in the digital active high mode
      next_c.ld = (c.bank[cocc_pkg::REG_GLOBAL][cocc_pkg::PLL_MUX_LSB +: cocc_pkg::PLL_MUX_W]
         == cocc_pkg::PLL_MUX_DLD_HIGH) && c.lock_s2;
   end

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         c <= '0;
         c.bank <= DEFAULT_BANK;
         c.snap <= DEFAULT_BANK;
      end else begin
         c <= next_c;
      end
   end

   assign S_AXI_BVALID = c.bvalid;
   assign S_AXI_BRESP = c.bresp;
   assign S_AXI_RVALID = c.rvalid;
   assign S_AXI_RDATA = c.rdata;
   assign S_AXI_RRESP = c.rresp;
   assign LOCK_DETECT_PIN = c.ld;

   // ==========================================================
   // Distribution clock next state
   always_comb begin
      next_d = d;
      next_d.req_s1 = c.req;
      next_d.req_s2 = d.req_s1;
      next_d.req_s3 = d.req_s2;
      // Snapshot is stable until the returned toggle is seen
      if (d.req_s2 != d.req_s3) begin
         next_d.cfg = c.snap;
      end
      next_d.goe_s1 = GLOBAL_OUTPUT_ENABLE_PIN;
      next_d.goe_s2 = d.goe_s1;
      next_d.sync_s1 = SYNC_N;
      next_d.sync_s2 = d.sync_s1;
      // A low shorter than one cycle may be missed entirely
      next_d.hold_pipe = {d.hold_pipe[cocc_pkg::SYNC_EXTRA_CYCLES-2:0], !d.sync_s2};
   end

   // Pins idle high after reset, as their pull-ups would leave them
   always_ff @(posedge DIST_CLK or negedge RSTN) begin
      if (!RSTN) begin
         d <= '0;
         d.cfg <= DEFAULT_BANK;
         d.goe_s1 <= 1'b1;
         d.goe_s2 <= 1'b1;
         d.sync_s1 <= 1'b1;
         d.sync_s2 <= 1'b1;
      end else begin
         d <= next_d;
      end
   end

   // ==========================================================
   // Output channels
   generate
      for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
         logic [cocc_pkg::WORD_W-1:0] w;
         assign w = d.cfg[i];
         cocc_output_channel u_chan (
            .dist_clk(DIST_CLK),
            .rstn(RSTN),
            .cfg_enable(w[cocc_pkg::EN_BIT]),
            .cfg_global(d.cfg[cocc_pkg::REG_GLOBAL][cocc_pkg::GLOBAL_EN_BIT]),
            .goe_level(d.goe_s2),
            .sync_hold(d.hold_pipe[cocc_pkg::SYNC_EXTRA_CYCLES-1]),
            .cfg_mux(w[cocc_pkg::MUX_LSB +: cocc_pkg::MUX_W]),
            .cfg_div(w[cocc_pkg::DIV_LSB +: cocc_pkg::DIV_W]),
            .cfg_dly(w[cocc_pkg::DLY_LSB +: cocc_pkg::DLY_W]),
            .clk_out(CLK_OUT[i]),
            .clk_out_oe(CLK_OUT_OE[i]),
            .out_delay(PER_OUTPUT_DELAY[i*cocc_pkg::DLY_W +: cocc_pkg::DLY_W])
         );
      end
   endgenerate

endmodule : cocc_clock_output_control
`default_nettype wire

// ==== tb/cocc_props.sv ====
// Port-level properties of the clock output control top
`timescale 1ns/1ps
`default_nettype none
module cocc_props #(
   parameter int NUM_OUT = cocc_pkg::NUM_OUT
) (
   input wire logic CORE_CLK,
   input wire logic RSTN,
   input wire logic DIST_CLK,
   input wire logic SYNC_N,
   input wire logic PLL_LOCKED,
   input wire logic LOCK_DETECT_PIN,
   input wire logic [NUM_OUT-1:0] CLK_OUT,
   input wire logic [NUM_OUT-1:0] CLK_OUT_OE,
   input wire logic [NUM_OUT*cocc_pkg::DLY_W-1:0] PER_OUTPUT_DELAY,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   input wire logic [cocc_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [cocc_pkg::WORD_W-1:0] S_AXI_RDATA,
   input wire logic [1:0] S_AXI_RRESP,
   input wire logic S_AXI_RVALID
);
   // ==========================================================
   // Sync low duration
   // Bound covers the lag plus the widest possible high phase
   logic [7:0] low_count;
   always_ff @(posedge DIST_CLK or negedge RSTN) begin
      if (!RSTN) begin
         low_count <= 8'h00;
      end else if (SYNC_N) begin
         low_count <= 8'h00;
      end else if (low_count != 8'hff) begin
         low_count <= low_count + 8'h01;
      end
   end

   // ==========================================================
   // Bus
   // Both beats are parked one cycle before the response is raised
   AST_WR_RESP: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
      else $error("write response missing");
   AST_WR_REFUSE: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write accepted during response");
   AST_RD_RESP: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read response missing");
   AST_RD_REFUSE: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read accepted during response");
   AST_RD_ERR: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 8'h40
      |=> S_AXI_RRESP == cocc_pkg::RESP_SLVERR && S_AXI_RDATA == '0)
      else $error("unmapped read not refused");

   // ==========================================================
   // Outputs
   AST_OFF_QUIET: assert property (@(posedge DIST_CLK) disable iff (!RSTN)
      (CLK_OUT & ~CLK_OUT_OE) == '0)
      else $error("undriven output toggles");
   AST_SYNC_HOLD: assert property (@(posedge DIST_CLK) disable iff (!RSTN)
      low_count >= 8'h8c |-> CLK_OUT == '0)
      else $error("output high during sync hold");
   AST_SYNC_LAG: assert property (@(posedge DIST_CLK) disable iff (!RSTN)
      $rose(SYNC_N) && low_count >= 8'h8c |-> (CLK_OUT == '0) [*5])
      else $error("outputs rose too early after sync");
   AST_LD_FOLLOW: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      LOCK_DETECT_PIN |-> $past(PLL_LOCKED, 2) || $past(PLL_LOCKED, 3) || $past(PLL_LOCKED, 4))
      else $error("lock detect high while unlocked");
   AST_RESET_OUT: assert property (@(posedge DIST_CLK) disable iff (!RSTN)
      $rose(RSTN) |-> CLK_OUT_OE == '0 && PER_OUTPUT_DELAY == '0)
      else $error("outputs not at defaults after reset");
endmodule : cocc_props

bind cocc_clock_output_control cocc_props #(.NUM_OUT(NUM_OUT)) u_cocc_props (
   .CORE_CLK(CORE_CLK), .RSTN(RSTN), .DIST_CLK(DIST_CLK), .SYNC_N(SYNC_N), .PLL_LOCKED(PLL_LOCKED),
   .LOCK_DETECT_PIN(LOCK_DETECT_PIN), .CLK_OUT(CLK_OUT), .CLK_OUT_OE(CLK_OUT_OE),
   .PER_OUTPUT_DELAY(PER_OUTPUT_DELAY), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID)
);
`default_nettype wire

// ==== tb/cocc_host_model.sv ====
// Serial configuration host driving the three-wire port
`timescale 1ns/1ps
`default_nettype none
module cocc_host_model (
   output logic scfg_clk,
   output logic scfg_data,
   output logic scfg_latch
);
   // ==========================================================
   // Word transfer
   // Clock stands still between words, 80 ns period inside them
   initial begin
      scfg_clk = 1'b0;
      scfg_data = 1'b0;
      scfg_latch = 1'b0;
   end

   task automatic send(input logic [31:0] word);
      #13;
      for (int i = 31; i >= 0; i--) begin
         scfg_data = word[i];
         #40 scfg_clk = 1'b1;
         #40 scfg_clk = 1'b0;
      end
      #40 scfg_latch = 1'b1;
      #40 scfg_latch = 1'b0;
      scfg_data = 1'b0;
   endtask : send
endmodule : cocc_host_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the clock output control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ==========================================================
   // Clocks, pins and bus
   logic core_clk = 1'b0;
   logic dist_clk = 1'b0;
   logic rstn = 1'b0;
   logic global_output_enable_pin = 1'b1;
   logic use_ld = 1'b0;
   logic sync_n = 1'b1;
   logic pll_locked = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic [3:0] wstrb = 4'hf;
   logic arvalid = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, ld, scfg_clk, scfg_data, scfg_latch;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, dly, d;
   logic [7:0] clk_out, oe;
   logic [1:0] r;
   wire logic goe_pin;
   int fail_count = 0;
   int total_checks = 0;
   logic [7:0] mask = 8'h4a;
   logic [31:0] cfg [3] = '{32'h0001_0051, 32'h0005_04a3, 32'h0007_04f6};

   always #2.5 core_clk = ~core_clk;
   always #3.6 dist_clk = ~dist_clk;
   // Lock detect looped back onto the enable pin when asked
   assign goe_pin = use_ld ? ld : global_output_enable_pin;

   cocc_host_model u_cocc_host_model (.scfg_clk(scfg_clk), .scfg_data(scfg_data), .scfg_latch(scfg_latch));

   cocc_clock_output_control u_cocc_clock_output_control (
      .CORE_CLK(core_clk), .RSTN(rstn), .SERIAL_CFG_CLOCK(scfg_clk), .SERIAL_CFG_DATA(scfg_data),
      .SERIAL_CFG_LATCH(scfg_latch), .DIST_CLK(dist_clk), .GLOBAL_OUTPUT_ENABLE_PIN(goe_pin), .SYNC_N(sync_n),
      .PLL_LOCKED(pll_locked), .LOCK_DETECT_PIN(ld), .CLK_OUT(clk_out), .CLK_OUT_OE(oe), .PER_OUTPUT_DELAY(dly),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(1'b1)
   );

   // ==========================================================
   // Reporting
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test

   task automatic guard(input int n);
      if (n >= 300) begin
         fail_count++;
         end_of_test();
      end
   endtask : guard

   // ==========================================================
   // Bus cycles, entered just after a core edge
   // Ready for responses is tied high, so each answer is taken when seen
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] w, output logic [1:0] resp);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= w;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         n++;
      end while (!bvalid && n < 300);
      guard(n);
      resp = bresp;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] data, output logic [1:0] resp);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge core_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         n++;
      end while (!rvalid && n < 300);
      guard(n);
      data = rdata;
      resp = rresp;
   endtask : axi_rd

   // Waits until the pending flag drops, then lets outputs catch up
   task automatic settle();
      int n;
      n = 0;
      repeat (4) @(posedge core_clk);
      do begin
         axi_rd(8'h40, d, r);
         n++;
      end while (d[0] !== 1'b0 && n < 300);
      guard(n);
      repeat (12) @(posedge dist_clk);
      @(posedge core_clk);
   endtask : settle

   task automatic watch(output logic [7:0] seen);
      seen = 8'h00;
      repeat (16) begin
         @(posedge dist_clk);
         seen = seen | clk_out;
      end
      @(posedge core_clk);
   endtask : watch

   // ==========================================================
   // Sequence
   initial begin
      int n;
      logic [7:0] seen;
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      for (int i = 0; i < 16; i++) begin
         axi_rd(8'(i * 4), d, r);
         check(d, (i == 14) ? 32'h0800_000e : 32'(i));
      end
      check(32'(oe), 32'h0);
      axi_rd(8'h44, d, r);
      check(32'(r), 32'(cocc_pkg::RESP_SLVERR));
      check(d, 32'h0);
      axi_wr(8'h40, 32'h0000_0003, r);
      check(32'(r), 32'(cocc_pkg::RESP_SLVERR));
      // Only the low byte lane lands, the rest keeps the default
      wstrb <= 4'h1;
      axi_wr(8'h14, 32'hffff_ffa5, r);
      check(32'(r), 32'(cocc_pkg::RESP_OKAY));
      wstrb <= 4'hf;
      axi_rd(8'h14, d, r);
      check(d, 32'h0000_00a5);
      for (int i = 0; i < 3; i++) u_cocc_host_model.send(cfg[i]);
      settle();
      for (int i = 0; i < 3; i++) begin
         axi_rd({2'h0, cfg[i][3:0], 2'h0}, d, r);
         check(d, cfg[i]);
      end
      check(dly, 32'h0f00_a000);
      check(32'(oe), 32'(mask));
      watch(seen);
      check(32'(seen), 32'(mask));
      use_ld <= 1'b1;
      axi_wr(8'h38, 32'h0830_000e, r);
      settle();
      check(32'(ld), 32'h0);
      watch(seen);
      check(32'(seen), 32'h0);
      check(32'(oe), 32'(mask));
      pll_locked <= 1'b1;
      settle();
      check(32'(ld), 32'h1);
      watch(seen);
      check(32'(seen), 32'(mask));
      axi_wr(8'h38, 32'h0030_000e, r);
      settle();
      check(32'(oe), 32'h0);
      axi_wr(8'h38, 32'h0830_000e, r);
      settle();
      sync_n <= 1'b0;
      repeat (150) @(posedge dist_clk);
      check(32'(clk_out), 32'h0);
      @(posedge core_clk);
      sync_n <= 1'b1;
      n = 0;
      do begin
         @(posedge dist_clk);
         n++;
      end while (clk_out === 8'h00 && n < 300);
      guard(n);
      check(32'(n > 4), 32'h1);
      check(32'(clk_out), 32'(mask));
      u_cocc_host_model.send(32'h8000_0ff0);
      settle();
      axi_rd(8'h0c, d, r);
      check(d, 32'h3);
      axi_rd(8'h00, d, r);
      check(d, 32'h0);
      check(32'(oe), 32'h0);
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
